// ### rtl/tcu_counter_unit.sv
// 16-bit timer counter with shared high-byte latch on an 8-bit CPU bus.
`timescale 1ns/100ps
`default_nettype none
`include "tcu_params.svh"

module tcu_counter_unit (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire logic [`TCU_ADDR_W-1:0] io_addr_i,
  input  wire logic                   io_wr_i,
  input  wire logic                   io_rd_i,
  input  wire logic [7:0]             io_wdata_i,
  input  wire logic [`TCU_NUM_SRC-1:0] timer_tick_src_i,
  output logic      [7:0]             io_rdata_o,
  output logic      [15:0]            timer_count_o,
  output logic                        count_overflow_flag_o,
  output logic                        count_floor_hit_o,
  output logic                        count_top_hit_o
);

  // ****************************************************************
  // State and mode decode
  // ****************************************************************
  tcu_pkg::tcu_state_t st_r;
  tcu_pkg::tcu_state_t st_nxt;
  tcu_pkg::tcu_seq_t   seq;
  tcu_pkg::tcu_ovf_t   ovf_pt;
  logic [15:0]         top;
  logic                cap_is_top;
  logic [3:0]          waveform_mode_select;
  logic [2:0]          clock_source_select;
  logic                timer_tick;
  logic                wr_lo_cnt;
  logic                ovf_evt;

  assign waveform_mode_select = {st_r.ctl_b[`TCU_CTLB_WGM_MSB:`TCU_CTLB_WGM_LSB],
                                 st_r.ctl_a[`TCU_CTLA_WGM_MSB:`TCU_CTLA_WGM_LSB]};
  assign clock_source_select  = st_r.ctl_b[`TCU_CTLB_CS_MSB:`TCU_CTLB_CS_LSB];

  assign timer_tick = (clock_source_select != `TCU_CS_STOP) &&
                      timer_tick_src_i[clock_source_select - 3'h1];

  assign wr_lo_cnt = io_wr_i && (io_addr_i == `TCU_OFS_CNT_LO);

  tcu_mode_decode u_mode (
    .waveform_mode_select_i (waveform_mode_select),
    .cmp_a_i                (st_r.cmp_a),
    .cap_i                  (st_r.cap),
    .seq_o                  (seq),
    .ovf_o                  (ovf_pt),
    .top_o                  (top),
    .cap_is_top_o           (cap_is_top)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt  = st_r;
    ovf_evt = 1'b0;

    if (timer_tick) begin
      case (ovf_pt)
        tcu_pkg::TCU_OVF_AT_TOP:   ovf_evt = (st_r.cnt == top);
        tcu_pkg::TCU_OVF_AT_FLOOR: ovf_evt = (st_r.cnt == `TCU_RST_WORD) && st_r.down;
        default:                   ovf_evt = (st_r.cnt == `TCU_CNT_MAX);
      endcase
    end

    if (timer_tick) begin
      case (seq)
        tcu_pkg::TCU_SEQ_CLR_TOP: begin
          if (st_r.cnt == top) begin
            st_nxt.cnt = `TCU_RST_WORD;
          end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
          end
        end
        tcu_pkg::TCU_SEQ_DUAL: begin
          if (!st_r.down && st_r.cnt >= top) begin
            st_nxt.down = 1'b1;
            st_nxt.cnt  = st_r.cnt - 16'h0001;
          end else if (st_r.down && st_r.cnt == `TCU_RST_WORD) begin
            st_nxt.down = 1'b0;
            st_nxt.cnt  = st_r.cnt + 16'h0001;
          end else if (st_r.down) begin
            st_nxt.cnt  = st_r.cnt - 16'h0001;
          end else begin
            st_nxt.cnt  = st_r.cnt + 16'h0001;
          end
        end
        default: begin
          st_nxt.cnt  = st_r.cnt + 16'h0001;
          st_nxt.down = 1'b0;
        end
      endcase
    end

    // Leaving a dual-slope mode must not leave the counter stuck counting down.
    if (seq != tcu_pkg::TCU_SEQ_DUAL) begin
      st_nxt.down = 1'b0;
    end

    // Set wins over a software clear in the same cycle.
    if (io_wr_i && io_addr_i == `TCU_OFS_FLAGS && io_wdata_i[`TCU_FLAGS_OVF_BIT]) begin
      st_nxt.ovf = 1'b0;
    end
    if (ovf_evt) begin
      st_nxt.ovf = 1'b1;
    end

    // ****************************************************************
    // CPU writes
    // ****************************************************************
    // access needs no tick
    if (io_wr_i) begin
      case (io_addr_i)
        `TCU_OFS_CTL_A: st_nxt.ctl_a = io_wdata_i;
        `TCU_OFS_CTL_B: st_nxt.ctl_b = io_wdata_i;
        `TCU_OFS_CNT_HI, `TCU_OFS_CAP_HI, `TCU_OFS_CMPA_HI, `TCU_OFS_CMPB_HI: begin
          st_nxt.hi_latch = io_wdata_i;
        end
        `TCU_OFS_CNT_LO:  st_nxt.cnt   = {st_r.hi_latch, io_wdata_i};
        `TCU_OFS_CMPA_LO: st_nxt.cmp_a = {st_r.hi_latch, io_wdata_i};
        `TCU_OFS_CMPB_LO: st_nxt.cmp_b = {st_r.hi_latch, io_wdata_i};
        `TCU_OFS_CAP_LO: begin
          // The capture register only takes writes while it defines the top.
          if (cap_is_top) begin
            st_nxt.cap = {st_r.hi_latch, io_wdata_i};
          end
        end
        default: begin
        end
      endcase
    end

    // ****************************************************************
    // CPU reads
    // ****************************************************************
    if (io_rd_i) begin
      case (io_addr_i)
        `TCU_OFS_CTL_A: st_nxt.rdata = st_r.ctl_a;
        `TCU_OFS_CTL_B: st_nxt.rdata = st_r.ctl_b;
        `TCU_OFS_CNT_LO: begin
          st_nxt.rdata    = st_r.cnt[7:0];
          st_nxt.hi_latch = st_r.cnt[15:8];
        end
        `TCU_OFS_CAP_LO: begin
          st_nxt.rdata    = st_r.cap[7:0];
          st_nxt.hi_latch = st_r.cap[15:8];
        end
        `TCU_OFS_CNT_HI, `TCU_OFS_CAP_HI: st_nxt.rdata = st_r.hi_latch;
        `TCU_OFS_CMPA_LO: st_nxt.rdata = st_r.cmp_a[7:0];
        `TCU_OFS_CMPA_HI: st_nxt.rdata = st_r.cmp_a[15:8];
        `TCU_OFS_CMPB_LO: st_nxt.rdata = st_r.cmp_b[7:0];
        `TCU_OFS_CMPB_HI: st_nxt.rdata = st_r.cmp_b[15:8];
        `TCU_OFS_FLAGS:   st_nxt.rdata = {7'h00, st_r.ovf};
        default:          st_nxt.rdata = `TCU_RST_BYTE;
      endcase
    end

    st_nxt.floor_hit = (st_nxt.cnt == `TCU_RST_WORD);
    st_nxt.top_hit   = (st_nxt.cnt == top);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r           <= '0;
      st_r.floor_hit <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io_rdata_o            = st_r.rdata;
  assign timer_count_o         = st_r.cnt;
  assign count_overflow_flag_o = st_r.ovf;
  assign count_floor_hit_o     = st_r.floor_hit;
  assign count_top_hit_o       = st_r.top_hit;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_low_write_pair: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_lo_cnt |=> timer_count_o == {$past(st_r.hi_latch), $past(io_wdata_i)})
    else $error("counter low write did not load both bytes");

  a_low_read_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
    io_rd_i && io_addr_i == `TCU_OFS_CNT_LO && !io_wr_i
    |=> st_r.hi_latch == $past(st_r.cnt[15:8]) && io_rdata_o == $past(st_r.cnt[7:0]))
    else $error("counter low read did not fill the latch");

  a_high_via_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
    io_rd_i && io_addr_i == `TCU_OFS_CNT_HI |=> io_rdata_o == $past(st_r.hi_latch))
    else $error("counter high read bypassed the latch");

  a_cmp_read_direct: assert property (@(posedge mclk_i) disable iff (rst_i)
    io_rd_i && !io_wr_i && (io_addr_i == `TCU_OFS_CMPA_LO || io_addr_i == `TCU_OFS_CMPB_LO)
    |=> $stable(st_r.hi_latch))
    else $error("compare read disturbed the latch");

  a_stop_no_count: assert property (@(posedge mclk_i) disable iff (rst_i)
    clock_source_select == `TCU_CS_STOP && !io_wr_i ##1
    clock_source_select == `TCU_CS_STOP && !io_wr_i |-> $stable(timer_count_o))
    else $error("counter moved with no clock source");

  a_write_priority: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_lo_cnt && timer_tick |=> timer_count_o == {$past(st_r.hi_latch), $past(io_wdata_i)})
    else $error("count step overrode a CPU write");

  a_step_by_one: assert property (@(posedge mclk_i) disable iff (rst_i)
    timer_tick && !io_wr_i && seq == tcu_pkg::TCU_SEQ_NORMAL
    |=> timer_count_o == $past(timer_count_o) + 16'h0001)
    else $error("normal mode step was not one");

  a_floor_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
    count_floor_hit_o == (timer_count_o == `TCU_RST_WORD))
    else $error("floor indication wrong");

  a_ovf_normal: assert property (@(posedge mclk_i) disable iff (rst_i)
    timer_tick && !io_wr_i && seq == tcu_pkg::TCU_SEQ_NORMAL && timer_count_o == `TCU_CNT_MAX
    |=> count_overflow_flag_o && timer_count_o == `TCU_RST_WORD)
    else $error("overflow not flagged at wrap");

endmodule // tcu_counter_unit
`default_nettype wire

// ### rtl/tcu_params.svh
// Register offsets, field positions and reset values of the 16-bit timer counter unit.
`ifndef TCU_PARAMS_SVH
`define TCU_PARAMS_SVH

// ****************************************************************
// I/O locations on the 8-bit CPU bus
// ****************************************************************
`define TCU_ADDR_W          4
`define TCU_OFS_CTL_A       4'h0
`define TCU_OFS_CTL_B       4'h1
`define TCU_OFS_CNT_LO      4'h4
`define TCU_OFS_CNT_HI      4'h5
`define TCU_OFS_CAP_LO      4'h6
`define TCU_OFS_CAP_HI      4'h7
`define TCU_OFS_CMPA_LO     4'h8
`define TCU_OFS_CMPA_HI     4'h9
`define TCU_OFS_CMPB_LO     4'ha
`define TCU_OFS_CMPB_HI     4'hb
`define TCU_OFS_FLAGS       4'hc

// ****************************************************************
// Field positions
// ****************************************************************
`define TCU_CTLA_WGM_LSB    0
`define TCU_CTLA_WGM_MSB    1
`define TCU_CTLB_CS_LSB     0
`define TCU_CTLB_CS_MSB     2
`define TCU_CTLB_WGM_LSB    3
`define TCU_CTLB_WGM_MSB    4
`define TCU_FLAGS_OVF_BIT   0

// ****************************************************************
// Reset values and fixed counts
// ****************************************************************
`define TCU_RST_BYTE        8'h00
`define TCU_RST_WORD        16'h0000
`define TCU_CNT_MAX         16'hffff
`define TCU_TOP_8BIT        16'h00ff
`define TCU_TOP_9BIT        16'h01ff
`define TCU_TOP_10BIT       16'h03ff
`define TCU_CS_STOP         3'h0
`define TCU_NUM_SRC         7

`endif

// ### rtl/tcu_pkg.sv
// Types shared by the 16-bit timer counter unit.
package tcu_pkg;

  typedef enum logic [1:0] {
    TCU_SEQ_NORMAL,
    TCU_SEQ_CLR_TOP,
    TCU_SEQ_DUAL
  } tcu_seq_t;

  typedef enum logic [1:0] {
    TCU_OVF_AT_MAX,
    TCU_OVF_AT_TOP,
    TCU_OVF_AT_FLOOR
  } tcu_ovf_t;

  typedef struct packed {
    logic [7:0]  hi_latch;
    logic [15:0] cnt;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap;
    logic [7:0]  ctl_a;
    logic [7:0]  ctl_b;
    logic        down;
    logic        ovf;
    logic        floor_hit;
    logic        top_hit;
    logic [7:0]  rdata;
  } tcu_state_t;

endpackage

// ### rtl/tcu_mode_decode.sv
// Waveform mode decoder: count sequence, top value and overflow point per mode.
`timescale 1ns/100ps
`default_nettype none
`include "tcu_params.svh"

module tcu_mode_decode (
  input  wire logic [3:0]  waveform_mode_select_i,
  input  wire logic [15:0] cmp_a_i,
  input  wire logic [15:0] cap_i,
  output tcu_pkg::tcu_seq_t seq_o,
  output tcu_pkg::tcu_ovf_t ovf_o,
  output logic [15:0]      top_o,
  output logic             cap_is_top_o
);

  always_comb begin
    seq_o        = tcu_pkg::TCU_SEQ_NORMAL;
    ovf_o        = tcu_pkg::TCU_OVF_AT_MAX;
    top_o        = `TCU_CNT_MAX;
    cap_is_top_o = 1'b0;
    case (waveform_mode_select_i)
      4'h1, 4'h2, 4'h3: begin
        seq_o = tcu_pkg::TCU_SEQ_DUAL;
        ovf_o = tcu_pkg::TCU_OVF_AT_FLOOR;
      end
      4'h4: begin
        seq_o = tcu_pkg::TCU_SEQ_CLR_TOP;
      end
      4'h5, 4'h6, 4'h7: begin
        seq_o = tcu_pkg::TCU_SEQ_CLR_TOP;
        ovf_o = tcu_pkg::TCU_OVF_AT_TOP;
      end
      4'h8, 4'ha: begin
        seq_o        = tcu_pkg::TCU_SEQ_DUAL;
        ovf_o        = tcu_pkg::TCU_OVF_AT_FLOOR;
        cap_is_top_o = 1'b1;
      end
      4'h9, 4'hb: begin
        seq_o = tcu_pkg::TCU_SEQ_DUAL;
        ovf_o = tcu_pkg::TCU_OVF_AT_FLOOR;
      end
      4'hc: begin
        seq_o        = tcu_pkg::TCU_SEQ_CLR_TOP;
        cap_is_top_o = 1'b1;
      end
      4'he: begin
        seq_o        = tcu_pkg::TCU_SEQ_CLR_TOP;
        ovf_o        = tcu_pkg::TCU_OVF_AT_TOP;
        cap_is_top_o = 1'b1;
      end
      4'hf: begin
        seq_o = tcu_pkg::TCU_SEQ_CLR_TOP;
        ovf_o = tcu_pkg::TCU_OVF_AT_TOP;
      end
      default: begin
        seq_o = tcu_pkg::TCU_SEQ_NORMAL;
      end
    endcase
    // Fixed tops for the 8, 9 and 10 bit modes, else a register or the maximum.
    case (waveform_mode_select_i)
      4'h1, 4'h5:       top_o = `TCU_TOP_8BIT;
      4'h2, 4'h6:       top_o = `TCU_TOP_9BIT;
      4'h3, 4'h7:       top_o = `TCU_TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: top_o = cmp_a_i;
      4'h8, 4'ha, 4'hc, 4'he: top_o = cap_i;
      default:          top_o = `TCU_CNT_MAX;
    endcase
  end

endmodule // tcu_mode_decode
`default_nettype wire

// ### tb/tcu_cpu_model.sv
// CPU model that makes byte reads and writes on the timer's 8-bit I/O bus.
`timescale 1ns/100ps
`default_nettype none

module tcu_cpu_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] io_rdata_i,
  output logic      [3:0] io_addr_o,
  output logic            io_wr_o,
  output logic            io_rd_o,
  output logic      [7:0] io_wdata_o
);
  // ****************************************************************
  // Byte cycles, launched and released on the falling edge
  // ****************************************************************
  initial begin
    io_addr_o  = 4'h0;
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_wdata_o = 8'h00;
  end

  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    io_addr_o  = a;
    io_wdata_o = d;
    io_wr_o    = 1'b1;
    @(negedge mclk_i);
    io_wr_o    = 1'b0;
    // Released data lines show the inverse so stale values never look valid.
    io_wdata_o = ~d;
  endtask

  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    io_addr_o = a;
    io_rd_o   = 1'b1;
    @(negedge mclk_i);
    io_rd_o   = 1'b0;
    d         = io_rdata_i;
  endtask

  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr8(lo + 4'h1, v[15:8]);
    wr8(lo, v[7:0]);
  endtask

  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd8(lo, v[7:0]);
    rd8(lo + 4'h1, v[15:8]);
  endtask
endmodule // tcu_cpu_model

`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the 16-bit timer counter unit.
`timescale 1ns/100ps
`default_nettype none
`include "tcu_params.svh"

module tb;
  typedef struct packed {
    logic [3:0]  a;
    logic [15:0] v;
  } tcu_row_t;

  logic        mclk;
  logic        rst_i;
  logic [3:0]  io_addr;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic [6:0]  tick_src;
  logic [7:0]  io_rdata;
  logic [15:0] count;
  logic        ovf;
  logic        floor_hit;
  logic        top_hit;
  logic [15:0] w;
  logic [7:0]  b;
  int          failures;
  int          check_count;
  tcu_row_t    rows [6];

  tcu_counter_unit tcu_counter_unit_i (
    .mclk_i(mclk), .rst_i(rst_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
    .io_rd_i(io_rd), .io_wdata_i(io_wdata), .timer_tick_src_i(tick_src),
    .io_rdata_o(io_rdata), .timer_count_o(count), .count_overflow_flag_o(ovf),
    .count_floor_hit_o(floor_hit), .count_top_hit_o(top_hit));

  tcu_cpu_model tcu_cpu_model_i (
    .mclk_i(mclk), .io_rdata_i(io_rdata), .io_addr_o(io_addr), .io_wr_o(io_wr),
    .io_rd_o(io_rd), .io_wdata_o(io_wdata));

  // ****************************************************************
  // Clock, checks and closing
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input logic [6:0] m);
    @(negedge mclk);
    tick_src = m;
    @(negedge mclk);
    tick_src = 7'h00;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 8);
    failures++;
    end_sim();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    failures = 0;
    check_count = 0;
    tick_src = 7'h00;
    rst_i = 1'b1;
    rows = '{'{`TCU_OFS_CNT_LO, 16'h01ff}, '{`TCU_OFS_CNT_LO, 16'ha55a},
             '{`TCU_OFS_CMPA_LO, 16'h1234}, '{`TCU_OFS_CMPB_LO, 16'hfedc},
             '{`TCU_OFS_CNT_LO, 16'h0000}, '{`TCU_OFS_CNT_LO, 16'hffff}};
    repeat (3) @(negedge mclk);
    rst_i = 1'b0;
    check({count, 4'h0, ovf, floor_hit, top_hit, 1'b0}, 20'h00004);
    check(io_rdata, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      tcu_cpu_model_i.wr16(rows[i].a, rows[i].v);
      if (rows[i].a == `TCU_OFS_CNT_LO) check(count, rows[i].v);
      tcu_cpu_model_i.rd16(rows[i].a, w);
      check(w, rows[i].v);
    end
    $display("row tests done");
    tcu_cpu_model_i.wr16(`TCU_OFS_CNT_LO, 16'h5a01);
    tcu_cpu_model_i.wr16(`TCU_OFS_CMPA_LO, 16'hc3d4);
    tcu_cpu_model_i.rd8(`TCU_OFS_CNT_LO, b);
    tcu_cpu_model_i.rd16(`TCU_OFS_CMPA_LO, w);
    check(w, 16'hc3d4);
    tcu_cpu_model_i.rd8(`TCU_OFS_CNT_HI, b);
    check(b, 8'h5a);
    tcu_cpu_model_i.wr8(`TCU_OFS_CNT_HI, 8'h77);
    tcu_cpu_model_i.rd8(`TCU_OFS_CNT_HI, b);
    check({b, count}, 24'h775a01);
    tcu_cpu_model_i.wr8(`TCU_OFS_CMPA_HI, 8'h42);
    tcu_cpu_model_i.wr8(`TCU_OFS_CMPA_LO, 8'h10);
    tcu_cpu_model_i.wr8(`TCU_OFS_CMPB_LO, 8'h20);
    tcu_cpu_model_i.rd16(`TCU_OFS_CMPB_LO, w);
    check(w, 16'h4220);
    tcu_cpu_model_i.rd8(4'hf, b);
    check(b, 8'h00);
    $display("latch tests done");
    tcu_cpu_model_i.wr8(`TCU_OFS_CTL_B, 8'h01);
    tcu_cpu_model_i.wr16(`TCU_OFS_CNT_LO, 16'hfffe);
    tick(7'h01);
    check(count, 16'hffff);
    tick(7'h02);
    check(count, 16'hffff);
    tick(7'h01);
    @(negedge mclk);
    check({count, ovf, floor_hit}, 18'h00003);
    tcu_cpu_model_i.wr8(`TCU_OFS_FLAGS, 8'h01);
    tcu_cpu_model_i.rd8(`TCU_OFS_FLAGS, b);
    check(b[0], 1'b0);
    tcu_cpu_model_i.wr8(`TCU_OFS_CTL_B, 8'h00);
    tick(7'h7f);
    check(count, 16'h0000);
    tcu_cpu_model_i.wr8(`TCU_OFS_CTL_B, 8'h01);
    tcu_cpu_model_i.wr8(`TCU_OFS_CNT_HI, 8'h30);
    fork
      tick(7'h01);
      tcu_cpu_model_i.wr8(`TCU_OFS_CNT_LO, 8'h00);
    join
    check(count, 16'h3000);
    tcu_cpu_model_i.rd16(`TCU_OFS_CNT_LO, w);
    check(w, 16'h3000);
    $display("count tests done");
    tcu_cpu_model_i.wr8(`TCU_OFS_CTL_A, 8'h01);
    tcu_cpu_model_i.wr8(`TCU_OFS_CTL_B, 8'h09);
    tcu_cpu_model_i.wr16(`TCU_OFS_CNT_LO, 16'h00fe);
    tick(7'h01);
    check({count, top_hit}, 17'h001ff);
    tick(7'h01);
    @(negedge mclk);
    check({count, ovf}, 17'h00001);
    tcu_cpu_model_i.wr8(`TCU_OFS_CTL_B, 8'h01);
    tcu_cpu_model_i.wr16(`TCU_OFS_CNT_LO, 16'h00fe);
    tick(7'h01);
    tick(7'h01);
    check(count, 16'h00fe);
    tcu_cpu_model_i.wr8(`TCU_OFS_FLAGS, 8'h01);
    tcu_cpu_model_i.wr16(`TCU_OFS_CNT_LO, 16'h0001);
    tick(7'h01);
    tick(7'h01);
    check({count, ovf}, 17'h00003);
    tcu_cpu_model_i.wr8(`TCU_OFS_CTL_A, 8'h03);
    tcu_cpu_model_i.wr8(`TCU_OFS_CTL_B, 8'h19);
    tcu_cpu_model_i.wr16(`TCU_OFS_CMPA_LO, 16'h0003);
    tcu_cpu_model_i.wr8(`TCU_OFS_CNT_LO, 8'h02);
    tick(7'h01);
    check({count, top_hit}, 17'h00007);
    tcu_cpu_model_i.wr8(`TCU_OFS_FLAGS, 8'h01);
    tick(7'h01);
    check({count, ovf}, 17'h00001);
    tcu_cpu_model_i.wr8(`TCU_OFS_CTL_A, 8'h00);
    tcu_cpu_model_i.wr8(`TCU_OFS_CTL_B, 8'h18);
    tcu_cpu_model_i.wr16(`TCU_OFS_CAP_LO, 16'h0345);
    tcu_cpu_model_i.wr8(`TCU_OFS_CTL_B, 8'h00);
    tcu_cpu_model_i.wr16(`TCU_OFS_CAP_LO, 16'h1111);
    tcu_cpu_model_i.rd16(`TCU_OFS_CAP_LO, w);
    check(w, 16'h0345);
    $display("mode tests done");
    tcu_cpu_model_i.wr8(`TCU_OFS_CNT_LO, 8'h45);
    check(count, 16'h0345);
    @(negedge mclk);
    rst_i = 1'b1;
    @(negedge mclk);
    rst_i = 1'b0;
    check({count, io_rdata, ovf, floor_hit, top_hit}, 27'h0000002);
    tcu_cpu_model_i.rd8(`TCU_OFS_CNT_HI, b);
    check(b, 8'h00);
    $display("reset rerun done");
    end_sim();
  end
endmodule // tb

`default_nettype wire
